// File: design/cfs_params.svh
// constants for the charger fault supervisor: register offsets, fields,
// reset values and timing counts; included by the package and the core.
// assumes a 250 MHz system clock.
//
// Overview of operation
// - flying-cap short while charging: stop, mode 000, pin fault flag, irq
// - other faults stay detected and flagged during a flying-cap short
// - bus present: discharge flying caps before reverse block switch turns on
// - switch peak overcurrent while charging: flag, irq, stop, mode 000
// - battery above voltage threshold: gate drive holds it at threshold
// - entering voltage loop: set voltage loop flag and pulse irq
// - battery current above threshold: gate drive reduced to regulate
// - loop active 650ms with timer not disabled: stop, mode disable
// - dropout over threshold for selected deglitch time: stop, clear mode
// - die at 150C: stop charging, clear mode to disable
// - after overtemp trip no startup until die falls to 130C
// - switching rate defaults 500 kHz, three-bit field in register 0x01
// - mode 010 starts divider init; 000 means disabled
`ifndef CFS_PARAMS_SVH
`define CFS_PARAMS_SVH

`define CFS_CLK_MHZ 250
// register offsets
`define CFS_REG_MODE 8'h00
`define CFS_REG_RATE 8'h01
`define CFS_REG_DROP 8'h05
`define CFS_REG_CTRL 8'h06
`define CFS_REG_FLAG 8'h07
`define CFS_REG_STAT 8'h08
// fields
`define CFS_MODE_LSB 0
`define CFS_MODE_W 3
`define CFS_MODE_OFF 3'h0
`define CFS_MODE_DIV 3'h2
`define CFS_RATE_LSB 0
`define CFS_RATE_RST 3'h2
`define CFS_DROP_SEL_BIT 0
`define CFS_CTRL_TMR_DIS_BIT 0
`define CFS_FLAG_PIN_BIT 0
`define CFS_FLAG_PEAK_BIT 1
`define CFS_FLAG_VLOOP_BIT 2
`define CFS_FLAG_OTHER_BIT 3
`define CFS_FLAG_W 4
// timing
`define CFS_LOOP_TMO_MS 650
`define CFS_LOOP_TMO_CYC (`CFS_LOOP_TMO_MS * 1000 * `CFS_CLK_MHZ)
`define CFS_DROP_DEG_SHORT_US 10
`define CFS_DROP_DEG_LONG_US 100
`define CFS_DROP_SHORT_CYC (`CFS_DROP_DEG_SHORT_US * `CFS_CLK_MHZ)
`define CFS_DROP_LONG_CYC (`CFS_DROP_DEG_LONG_US * `CFS_CLK_MHZ)
`define CFS_DISCH_NS 1000
`define CFS_DISCH_CYC ((`CFS_DISCH_NS * `CFS_CLK_MHZ + 999) / 1000)

`endif

// File: design/cfs_pkg.sv
// types for the charger fault supervisor
// assumes cfs_params.svh on the include path
`include "cfs_params.svh"
package cfs_pkg;
    // analog comparator outputs, already deglitched by the analog front end
    typedef struct packed {
        logic flying_cap_short_fault;
        logic switch_peak_overcurrent;
        logic input_overcurrent_fault;
        logic battery_overvoltage_fault;
        logic dropout_overvoltage_fault;
        logic die_overtemp_fault;
        logic die_below_recover;
        logic battery_voltage_loop;
        logic battery_current_loop;
        logic bus_present;
    } cfs_sense_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cfs_bus_req_t;

    typedef enum logic [1:0] {
        CFS_IDLE,
        CFS_DISCHARGE,
        CFS_RUN
    } cfs_state_t;
endpackage

// File: design/cfs_core.sv
// charger fault supervisor: mode register, fault shutdown, loop timeout,
// dropout deglitch, overtemp lockout and startup sequencing.
// assumes comparator inputs synchronous to sys_clk_i and a host that drives
// the plain register port one strobe per cycle.
`include "cfs_params.svh"
module cfs_core
    import cfs_pkg::*;
#(
    parameter int unsigned LOOP_TMO_CYC = `CFS_LOOP_TMO_CYC,
    parameter int unsigned DROP_SHORT_CYC = `CFS_DROP_SHORT_CYC,
    parameter int unsigned DROP_LONG_CYC = `CFS_DROP_LONG_CYC
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire cfs_bus_req_t bus_i,
    output logic [7:0] rdata_o,
    input wire cfs_sense_t sense_i,
    output logic charging_o,
    output logic cap_discharge_o,
    output logic reverse_block_switch_o,
    output logic input_switch_gate_o,
    output logic gate_reduce_o,
    output logic irq_pulse_o,
    output logic [2:0] switching_rate_select_o
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic hit(input cfs_bus_req_t b, input logic [7:0] a);
        return b.wr && (b.addr == a);
    endfunction

    logic [2:0] charge_op_select_r;
    logic [2:0] switching_rate_select_r;
    logic dropout_filter_select_r;
    logic loop_timer_disable_r;
    logic [`CFS_FLAG_W-1:0] flags_r;
    logic otp_lock_r;
    logic vloop_d_r;
    logic [31:0] loop_cnt_r;
    logic [31:0] drop_cnt_r;
    logic [7:0] disch_cnt_r;
    logic irq_r;
    logic [7:0] rdata_r;
    cfs_state_t state_r;

    logic active;
    logic any_loop;
    logic loop_tmo;
    logic drop_trip;
    logic cap_trip;
    logic peak_trip;
    logic other_trip;
    logic fault;
    logic vloop_rise;
    logic [31:0] drop_lim;

    assign active = (charge_op_select_r != `CFS_MODE_OFF);
    assign any_loop = active && (sense_i.battery_voltage_loop
                                 || sense_i.battery_current_loop);
    assign loop_tmo = any_loop && !loop_timer_disable_r
                      && (loop_cnt_r >= LOOP_TMO_CYC - 1);
    assign drop_lim = dropout_filter_select_r ? DROP_LONG_CYC
                                              : DROP_SHORT_CYC;
    assign drop_trip = active && sense_i.dropout_overvoltage_fault
                       && (drop_cnt_r >= drop_lim - 1);
    assign cap_trip = active && sense_i.flying_cap_short_fault;
    assign peak_trip = active && sense_i.switch_peak_overcurrent;
    // evaluated independently of the cap short so both can flag at once
    assign other_trip = active && (sense_i.input_overcurrent_fault
                                   || sense_i.battery_overvoltage_fault);
    assign fault = cap_trip || peak_trip || other_trip || drop_trip
                   || loop_tmo
                   || (active && sense_i.die_overtemp_fault);
    assign vloop_rise = active && sense_i.battery_voltage_loop && !vloop_d_r;

    // ------------------------------------------------------------
    // charge mode register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            charge_op_select_r <= `CFS_MODE_OFF;
        end else if (fault) begin
            charge_op_select_r <= `CFS_MODE_OFF;
        end else if (hit(bus_i, `CFS_REG_MODE)) begin
            // a start is refused while the overtemp lockout holds
            // a trip in this very cycle refuses the write as well
            if (!otp_lock_r && !sense_i.die_overtemp_fault) begin
                charge_op_select_r <= bus_i.wdata[`CFS_MODE_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            switching_rate_select_r <= `CFS_RATE_RST;
            dropout_filter_select_r <= 1'b0;
            loop_timer_disable_r <= 1'b0;
        end else begin
            if (hit(bus_i, `CFS_REG_RATE)) begin
                switching_rate_select_r <= bus_i.wdata[2:0];
            end
            if (hit(bus_i, `CFS_REG_DROP)) begin
                dropout_filter_select_r <= bus_i.wdata[`CFS_DROP_SEL_BIT];
            end
            if (hit(bus_i, `CFS_REG_CTRL)) begin
                loop_timer_disable_r <= bus_i.wdata[`CFS_CTRL_TMR_DIS_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // flags: write one to clear, a new event wins over the clear
    // ------------------------------------------------------------
    logic [`CFS_FLAG_W-1:0] flag_set;
    logic [`CFS_FLAG_W-1:0] flag_clr;
    always_comb begin
        flag_set = '0;
        flag_set[`CFS_FLAG_PIN_BIT] = cap_trip;
        flag_set[`CFS_FLAG_PEAK_BIT] = peak_trip;
        flag_set[`CFS_FLAG_VLOOP_BIT] = vloop_rise;
        flag_set[`CFS_FLAG_OTHER_BIT] = other_trip;
        flag_clr = hit(bus_i, `CFS_REG_FLAG)
                   ? bus_i.wdata[`CFS_FLAG_W-1:0] : '0;
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            flags_r <= '0;
        end else begin
            flags_r <= (flags_r & ~flag_clr) | flag_set;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            irq_r <= 1'b0;
            vloop_d_r <= 1'b0;
        end else begin
            irq_r <= cap_trip || peak_trip || vloop_rise;
            vloop_d_r <= active && sense_i.battery_voltage_loop;
        end
    end

    // ------------------------------------------------------------
    // timers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            loop_cnt_r <= '0;
        end else if (!any_loop) begin
            loop_cnt_r <= '0;
        end else if (loop_cnt_r < LOOP_TMO_CYC - 1) begin
            loop_cnt_r <= loop_cnt_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            drop_cnt_r <= '0;
        end else if (!(active && sense_i.dropout_overvoltage_fault)) begin
            drop_cnt_r <= '0;
        end else if (drop_cnt_r < drop_lim - 1) begin
            drop_cnt_r <= drop_cnt_r + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // overtemp lockout, released only at the lower threshold
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            otp_lock_r <= 1'b0;
        end else if (sense_i.die_overtemp_fault) begin
            otp_lock_r <= 1'b1;
        end else if (sense_i.die_below_recover) begin
            otp_lock_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // startup: discharge flying caps, then close reverse block switch
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_r <= CFS_IDLE;
            disch_cnt_r <= '0;
        end else begin
            case (state_r)
                CFS_IDLE: begin
                    disch_cnt_r <= '0;
                    if (active && !fault && sense_i.bus_present) begin
                        state_r <= CFS_DISCHARGE;
                    end
                end
                CFS_DISCHARGE: begin
                    if (!active) begin
                        state_r <= CFS_IDLE;
                    end else if (disch_cnt_r >= 8'(`CFS_DISCH_CYC - 1)) begin
                        state_r <= CFS_RUN;
                    end else begin
                        disch_cnt_r <= disch_cnt_r + 8'h01;
                    end
                end
                CFS_RUN: begin
                    if (!active) begin
                        state_r <= CFS_IDLE;
                    end
                end
                default: state_r <= CFS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rdata_r <= '0;
        end else if (bus_i.rd) begin
            case (bus_i.addr)
                `CFS_REG_MODE: rdata_r <= {5'h00, charge_op_select_r};
                `CFS_REG_RATE: rdata_r <= {5'h00, switching_rate_select_r};
                `CFS_REG_DROP: rdata_r <= {7'h00, dropout_filter_select_r};
                `CFS_REG_CTRL: rdata_r <= {7'h00, loop_timer_disable_r};
                `CFS_REG_FLAG: rdata_r <= {4'h0, flags_r};
                `CFS_REG_STAT: rdata_r <= {4'h0, otp_lock_r, any_loop,
                                           state_r};
                default: rdata_r <= 8'h00;
            endcase
        end
    end

    assign rdata_o = rdata_r;
    assign charging_o = (state_r == CFS_RUN) && active;
    assign cap_discharge_o = (state_r == CFS_DISCHARGE);
    assign reverse_block_switch_o = charging_o;
    // gate held on while charging unless a regulation loop pulls it back
    assign gate_reduce_o = any_loop;
    assign input_switch_gate_o = charging_o && !any_loop;
    assign irq_pulse_o = irq_r;
    assign switching_rate_select_o = switching_rate_select_r;
endmodule

// File: sim/cfs_host_model.sv
// host side of the plain register port of the charger fault supervisor
// assumes one clock; strobes change only by NBA after a rising edge
module cfs_host_model
    import cfs_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic [7:0] rdata_i,
    output cfs_bus_req_t bus_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial bus_o = '0;
    // idle address and data are inverted so nothing leans on stale values
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        bus_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk_i);
        bus_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        bus_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk_i);
        bus_o <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
        @(posedge sys_clk_i);
        d = rdata_i;
    endtask
endmodule

// File: sim/cfs_checker.sv
// port assertions for cfs_core
// assumes the bind below and a single clock domain
module cfs_checker
    import cfs_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire cfs_bus_req_t bus_i,
    input wire logic [7:0] rdata_o,
    input wire cfs_sense_t sense_i,
    input wire logic charging_o,
    input wire logic cap_discharge_o,
    input wire logic reverse_block_switch_o,
    input wire logic input_switch_gate_o,
    input wire logic gate_reduce_o,
    input wire logic irq_pulse_o,
    input wire logic [2:0] switching_rate_select_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    // lockout as seen from the pins: set by overtemp, freed at recovery
    logic otp_hold_r;
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            otp_hold_r <= 1'b0;
        end else if (sense_i.die_overtemp_fault) begin
            otp_hold_r <= 1'b1;
        end else if (sense_i.die_below_recover) begin
            otp_hold_r <= 1'b0;
        end
    end
    a_cap_short_stop: assert property (
        charging_o && $rose(sense_i.flying_cap_short_fault)
        |=> !charging_o && irq_pulse_o) else $error("cap short missed");
    a_peak_stop: assert property (
        charging_o && $rose(sense_i.switch_peak_overcurrent)
        |=> !charging_o && irq_pulse_o) else $error("peak trip missed");
    a_vloop_irq: assert property (
        charging_o && $rose(sense_i.battery_voltage_loop)
        |=> irq_pulse_o) else $error("voltage loop irq missed");
    a_gate_regulate: assert property (
        charging_o && (sense_i.battery_voltage_loop
        || sense_i.battery_current_loop)
        |-> gate_reduce_o && !input_switch_gate_o)
        else $error("gate not regulating");
    a_discharge_first: assert property (
        $rose(reverse_block_switch_o) |-> $past(cap_discharge_o))
        else $error("switch on without discharge");
    a_overtemp_stop: assert property (
        charging_o && sense_i.die_overtemp_fault |=> !charging_o)
        else $error("overtemp did not stop");
    a_overtemp_lock: assert property (
        otp_hold_r && !cap_discharge_o |=> !cap_discharge_o)
        else $error("startup during overtemp lockout");
    a_rate_reset: assert property (
        $fell(srst_i) |-> switching_rate_select_o == 3'h2)
        else $error("rate reset value wrong");
    a_fault_wins: assert property (
        charging_o && sense_i.switch_peak_overcurrent && bus_i.wr
        && bus_i.addr == 8'h00 |=> !charging_o)
        else $error("mode write beat fault");
endmodule

bind cfs_core cfs_checker cfs_checker_inst (.sys_clk_i(sys_clk_i),
    .srst_i(srst_i), .bus_i(bus_i), .rdata_o(rdata_o), .sense_i(sense_i),
    .charging_o(charging_o), .cap_discharge_o(cap_discharge_o),
    .reverse_block_switch_o(reverse_block_switch_o),
    .input_switch_gate_o(input_switch_gate_o),
    .gate_reduce_o(gate_reduce_o), .irq_pulse_o(irq_pulse_o),
    .switching_rate_select_o(switching_rate_select_o));

// File: sim/tb_cfs_core.sv
// self-checking bench for cfs_core with shortened timing counts
// assumes cfs_host_model drives the register port
module tb_cfs_core
    import cfs_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    cfs_bus_req_t bus_i;
    cfs_sense_t sense_i = cfs_sense_t'(10'h009);
    logic [7:0] rdata_o;
    logic charging_o, cap_discharge_o, gate_reduce_o, irq_pulse_o;
    logic reverse_block_switch_o, input_switch_gate_o;
    logic [2:0] switching_rate_select_o;
    int n_mismatch = 0;
    int checks = 0;
    int cyc_n = 0;
    always #2 sys_clk_i = ~sys_clk_i;
    cfs_core #(.LOOP_TMO_CYC(50), .DROP_SHORT_CYC(5), .DROP_LONG_CYC(10))
    cfs_core_inst (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .bus_i(bus_i),
        .rdata_o(rdata_o), .sense_i(sense_i), .charging_o(charging_o),
        .cap_discharge_o(cap_discharge_o),
        .reverse_block_switch_o(reverse_block_switch_o),
        .input_switch_gate_o(input_switch_gate_o),
        .gate_reduce_o(gate_reduce_o),
        .irq_pulse_o(irq_pulse_o),
        .switching_rate_select_o(switching_rate_select_o));
    cfs_host_model host_inst (.sys_clk_i(sys_clk_i), .rdata_i(rdata_o),
        .bus_o(bus_i));
    task automatic complete_run;
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic start;
        logic seen;
        seen = 1'b0;
        host_inst.wr(8'h00, 8'h02);
        for (int k = 0; k < 400 && charging_o !== 1'b1; k++) begin
            @(posedge sys_clk_i);
            seen |= cap_discharge_o;
        end
        chk({7'h0, seen}, 8'h01);
        chk({7'h0, charging_o}, 8'h01);
        chk({7'h0, reverse_block_switch_o}, 8'h01);
        chk({7'h0, input_switch_gate_o}, 8'h01);
    endtask
    task automatic t_regs;
        logic [7:0] d;
        chk({5'h0, switching_rate_select_o}, 8'h02);
        host_inst.rd(8'h01, d);
        chk(d, 8'h02);
        host_inst.wr(8'h01, 8'h05);
        cyc(1);
        chk({5'h0, switching_rate_select_o}, 8'h05);
        host_inst.rd(8'h10, d);
        chk(d, 8'h00);
        $display("test regs done");
    endtask
    task automatic trip(input logic [9:0] m, input logic [7:0] fl);
        logic [7:0] d;
        start();
        sense_i <= cfs_sense_t'(10'h009 | m);
        cyc(2);
        chk({7'h0, charging_o}, 8'h00);
        chk({7'h0, irq_pulse_o}, 8'h01);
        host_inst.rd(8'h07, d);
        chk(d, fl);
        host_inst.rd(8'h00, d);
        chk(d, 8'h00);
        chk({7'h0, irq_pulse_o}, 8'h00);
        sense_i <= cfs_sense_t'(10'h009);
        host_inst.wr(8'h07, 8'hff);
        $display("test trip %h done", m);
    endtask
    task automatic race;
        logic [7:0] d;
        start();
        fork
            host_inst.wr(8'h00, 8'h02);
            begin
                @(posedge sys_clk_i);
                sense_i <= cfs_sense_t'(10'h109);
            end
        join
        cyc(3);
        chk({7'h0, cap_discharge_o}, 8'h00);
        chk({7'h0, charging_o}, 8'h00);
        host_inst.rd(8'h00, d);
        chk(d, 8'h00);
        sense_i <= cfs_sense_t'(10'h009);
        host_inst.wr(8'h07, 8'hff);
        $display("test race done");
    endtask
    task automatic loops;
        logic [7:0] d;
        start();
        sense_i <= cfs_sense_t'(10'h00d);
        cyc(30);
        chk({7'h0, gate_reduce_o}, 8'h01);
        chk({7'h0, input_switch_gate_o}, 8'h00);
        sense_i <= cfs_sense_t'(10'h009);
        cyc(1);
        sense_i <= cfs_sense_t'(10'h00b);
        cyc(40);
        chk({7'h0, charging_o}, 8'h01);
        chk({7'h0, gate_reduce_o}, 8'h01);
        chk({7'h0, input_switch_gate_o}, 8'h00);
        cyc(20);
        chk({7'h0, charging_o}, 8'h00);
        sense_i <= cfs_sense_t'(10'h009);
        host_inst.rd(8'h07, d);
        chk(d & 8'h04, 8'h04);
        host_inst.wr(8'h07, 8'hff);
        host_inst.wr(8'h06, 8'h01);
        start();
        sense_i <= cfs_sense_t'(10'h00b);
        cyc(80);
        chk({7'h0, charging_o}, 8'h01);
        sense_i <= cfs_sense_t'(10'h009);
        host_inst.wr(8'h06, 8'h00);
        host_inst.wr(8'h00, 8'h00);
        cyc(2);
        chk({7'h0, charging_o}, 8'h00);
        $display("test loops done");
    endtask
    task automatic drop(input logic [7:0] sel, input int lim);
        host_inst.wr(8'h05, sel);
        start();
        sense_i <= cfs_sense_t'(10'h029);
        cyc(lim - 2);
        sense_i <= cfs_sense_t'(10'h009);
        cyc(2);
        chk({7'h0, charging_o}, 8'h01);
        sense_i <= cfs_sense_t'(10'h029);
        cyc(lim - 1);
        chk({7'h0, charging_o}, 8'h01);
        cyc(4);
        chk({7'h0, charging_o}, 8'h00);
        sense_i <= cfs_sense_t'(10'h009);
        $display("test drop %0d done", lim);
    endtask
    task automatic otp;
        start();
        sense_i <= cfs_sense_t'(10'h011);
        cyc(2);
        chk({7'h0, charging_o}, 8'h00);
        sense_i <= cfs_sense_t'(10'h001);
        host_inst.wr(8'h00, 8'h02);
        cyc(300);
        chk({7'h0, charging_o}, 8'h00);
        sense_i <= cfs_sense_t'(10'h009);
        start();
        $display("test otp done");
    endtask
    initial begin
        cyc(16);
        srst_i <= 1'b0;
        t_regs();
        trip(10'h280, 8'h09);
        trip(10'h140, 8'h0a);
        race();
        loops();
        drop(8'h00, 5);
        drop(8'h01, 10);
        otp();
        complete_run();
    end
endmodule
